// [wiper_map.svh]
// register offsets, reset values, field positions and timing counts
// assumes a 200 MHz mclk
`ifndef WIPER_MAP_SVH
`define WIPER_MAP_SVH

`define WIPER_OFFSET    8'h00
`define WIPER_W         7
`define WIPER_RST       7'h40
`define BITS_PER_BYTE   4'h8
`define DIR_BIT         0
`define DIR_READ        1'b1
`define CLK_PERIOD_NS   5
`define PWRUP_NS        1000
`define PWRUP_CYC       ((`PWRUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [wiper_pkg.sv]
// types shared by the wiper slave and its helpers
// assumes wiper_map.svh holds the numbers
package wiper_pkg;

  typedef enum logic [3:0] {
    st_idle,
    st_id,
    st_id_ack,
    st_addr,
    st_addr_ack,
    st_wdata,
    st_wdata_ack,
    st_tx,
    st_tx_ack
  } slave_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } bus_events_s;

endpackage

// [pin_sync.sv]
// three-flop synchroniser with agreement filter, one lane per pin
// assumes pins are asynchronous to mclk
module pin_sync
  import wiper_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire logic      clk_en,
  input  wire bus_pins_s pins_in,
  output bus_pins_s      pins_out
);

  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  logic [1:0] lvl_q;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_lane
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          s1_q[i]  <= 1'b1;
          s2_q[i]  <= 1'b1;
          s3_q[i]  <= 1'b1;
          lvl_q[i] <= 1'b1;
        end else if (clk_en) begin
          s1_q[i] <= pins_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          // a change counts only when stages two and three agree
          if (s2_q[i] == s3_q[i]) begin
            lvl_q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

  assign pins_out = lvl_q;

endmodule

// [bus_cond.sv]
// start, stop and scl edge detection on filtered bus levels
// assumes both inputs are already synchronised to mclk
module bus_cond
  import wiper_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire logic      clk_en,
  input  wire bus_pins_s lvl,
  output bus_events_s    ev
);

  bus_pins_s prev_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_q <= '1;
    end else if (clk_en) begin
      prev_q <= lvl;
    end
  end

  always_comb begin
    ev.start = clk_en & prev_q.scl & lvl.scl & prev_q.sda & ~lvl.sda;
    ev.stop  = clk_en & prev_q.scl & lvl.scl & ~prev_q.sda & lvl.sda;
    ev.rise  = clk_en & ~prev_q.scl & lvl.scl;
    ev.fall  = clk_en & prev_q.scl & ~lvl.scl;
  end

endmodule

// [serial_wiper_position_slave.sv]
// two-wire slave holding a seven-bit wiper position
// assumes scl and sda arrive from pins; sda is open drain
`include "wiper_map.svh"

module serial_wiper_position_slave
  import wiper_pkg::*;
#(
  parameter logic [6:0] DEV_CODE = 7'h55  // arbitrary value
)
(
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  output logic [`WIPER_W-1:0]         wiper_pos,
  output logic                        pwrup_busy
);

  // ----------------------------------------------------------------
  // pin conditioning
  // ----------------------------------------------------------------

  bus_pins_s   pins_raw;
  bus_pins_s   lvl;
  bus_events_s ev;

  assign pins_raw = '{scl: scl_in, sda: sda_in};

  pin_sync u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .clk_en   (clk_en),
    .pins_in  (pins_raw),
    .pins_out (lvl)
  );

  bus_cond u_cond (
    .mclk   (mclk),
    .rst    (rst),
    .clk_en (clk_en),
    .lvl    (lvl),
    .ev     (ev)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------

  slave_state_e        state_q;
  logic [3:0]          cnt_q;
  logic [7:0]          shift_q;
  logic [7:0]          tx_q;
  logic [`WIPER_W-1:0] wiper_q;
  logic                dir_rd_q;
  logic                mack_q;
  logic                sda_oe_q;
  logic                sda_out_q;
  logic [7:0]          pwr_cnt_q;
  logic                pwr_busy_q;

  logic                start_ok;
  logic                byte_done;
  logic                id_ok;
  logic                addr_ok;
  logic                rx_state;

  assign start_ok  = ev.start & ~pwr_busy_q;
  assign byte_done = ev.fall & (cnt_q == `BITS_PER_BYTE);
  assign id_ok     = (shift_q[7:1] == DEV_CODE);
  assign addr_ok   = (shift_q == `WIPER_OFFSET);
  assign rx_state  = (state_q == st_id) | (state_q == st_addr) | (state_q == st_wdata);

  // ----------------------------------------------------------------
  // power-up sequence
  // ----------------------------------------------------------------

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwr_cnt_q  <= 8'h00;
      pwr_busy_q <= 1'b1;
    end else if (clk_en && pwr_busy_q) begin
      if (pwr_cnt_q == 8'(`PWRUP_CYC - 1)) begin
        pwr_busy_q <= 1'b0;
      end
      pwr_cnt_q <= pwr_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // protocol sequencer
  // ----------------------------------------------------------------

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= st_idle;
    end else if (start_ok) begin
      state_q <= st_id;
    end else if (ev.stop) begin
      state_q <= st_idle;
    end else if (ev.fall) begin
      case (state_q)
        st_id: begin
          if (byte_done) begin
            state_q <= id_ok ? st_id_ack : st_idle;
          end
        end
        st_id_ack: begin
          state_q <= dir_rd_q ? st_tx : st_addr;
        end
        st_addr: begin
          if (byte_done) begin
            state_q <= addr_ok ? st_addr_ack : st_idle;
          end
        end
        st_addr_ack: begin
          state_q <= st_wdata;
        end
        st_wdata: begin
          if (byte_done) begin
            state_q <= st_wdata_ack;
          end
        end
        st_wdata_ack: begin
          state_q <= st_idle;
        end
        st_tx: begin
          if (byte_done) begin
            state_q <= st_tx_ack;
          end
        end
        st_tx_ack: begin
          state_q <= mack_q ? st_tx : st_idle;
        end
        default: begin
          state_q <= st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bit counter
  // ----------------------------------------------------------------

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else if (start_ok) begin
      cnt_q <= 4'h0;
    end else if (byte_done) begin
      cnt_q <= 4'h0;
    end else if (ev.rise && (rx_state || state_q == st_tx)) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // receive shifter and direction
  // ----------------------------------------------------------------

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shift_q <= 8'h00;
    end else if (ev.rise && rx_state) begin
      shift_q <= {shift_q[6:0], lvl.sda};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dir_rd_q <= 1'b0;
    end else if (byte_done && state_q == st_id) begin
      dir_rd_q <= (shift_q[`DIR_BIT] == `DIR_READ);
    end
  end

  // ----------------------------------------------------------------
  // master acknowledge during read
  // ----------------------------------------------------------------

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mack_q <= 1'b0;
    end else if (ev.rise && state_q == st_tx_ack) begin
      mack_q <= ~lvl.sda;
    end
  end

  // ----------------------------------------------------------------
  // wiper position register
  // ----------------------------------------------------------------

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wiper_q <= `WIPER_RST;
    end else if (byte_done && state_q == st_wdata) begin
      wiper_q <= shift_q[`WIPER_W-1:0];
    end
  end

  // code drives the tap select directly, so taps follow the code in order
  assign wiper_pos = wiper_q;

  // ----------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_q <= 8'h00;
    end else if (ev.fall) begin
      if ((state_q == st_id_ack && dir_rd_q) || (state_q == st_tx_ack && mack_q)) begin
        tx_q <= {1'b0, wiper_q};
      end else if (state_q == st_tx) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // sda driver, changed on scl falling edges and released at a start or stop
  // ----------------------------------------------------------------

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sda_oe_q <= 1'b0;
    end else if (start_ok || ev.stop) begin
      sda_oe_q <= 1'b0;
    end else if (ev.fall) begin
      case (state_q)
        st_id: begin
          sda_oe_q <= byte_done & id_ok;
        end
        st_addr: begin
          sda_oe_q <= byte_done & addr_ok;
        end
        st_wdata: begin
          sda_oe_q <= byte_done;
        end
        st_id_ack: begin
          sda_oe_q <= dir_rd_q;  // msb of the read byte is zero
        end
        st_tx: begin
          sda_oe_q <= byte_done ? 1'b0 : ~tx_q[6];
        end
        st_tx_ack: begin
          sda_oe_q <= mack_q;
        end
        default: begin
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sda_out_q <= 1'b0;
    end else if (clk_en) begin
      sda_out_q <= 1'b0;
    end
  end

  assign sda_oe     = sda_oe_q;
  assign sda_out    = sda_out_q;
  assign pwrup_busy = pwr_busy_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  a_por_midscale: assert property (
    @(posedge mclk) $fell(rst) |-> (wiper_q == `WIPER_RST))
    else $error("wiper not at midscale after reset");

  a_pwrup_start: assert property (
    @(posedge mclk) disable iff (rst)
    (pwr_busy_q && ev.start && state_q == st_idle) |=> (state_q == st_idle))
    else $error("start taken during power-up");

  a_sda_low_scl: assert property (
    @(posedge mclk) disable iff (rst)
    (sda_oe_q != $past(sda_oe_q)) && !$past(ev.start) && !$past(ev.stop) |-> !lvl.scl)
    else $error("sda changed while scl high");

  a_idle_release: assert property (
    @(posedge mclk) disable iff (rst)
    (state_q == st_idle) |-> !sda_oe_q)
    else $error("sda driven while idle");

  a_id_ack: assert property (
    @(posedge mclk) disable iff (rst)
    (byte_done && state_q == st_id && id_ok && !start_ok && !ev.stop)
      |=> sda_oe_q && (state_q == st_id_ack))
    else $error("valid id not acknowledged");

  a_bad_addr: assert property (
    @(posedge mclk) disable iff (rst)
    (byte_done && state_q == st_addr && !addr_ok && !start_ok && !ev.stop)
      |=> !sda_oe_q && (state_q == st_idle))
    else $error("bad address acknowledged");

  a_wiper_load: assert property (
    @(posedge mclk) disable iff (rst)
    (byte_done && state_q == st_wdata && !start_ok && !ev.stop)
      |=> (wiper_q == $past(shift_q[6:0])) && (state_q == st_wdata_ack))
    else $error("write data not loaded");

  a_read_msb: assert property (
    @(posedge mclk) disable iff (rst)
    (ev.fall && state_q == st_id_ack && dir_rd_q && !start_ok && !ev.stop)
      |=> sda_oe_q && (tx_q[7] == 1'b0) && (state_q == st_tx))
    else $error("read byte msb not zero");

  a_read_end: assert property (
    @(posedge mclk) disable iff (rst)
    (ev.fall && state_q == st_tx_ack && !mack_q && !start_ok && !ev.stop)
      |=> (state_q == st_idle) && !sda_oe_q)
    else $error("read continued without master ack");

  a_tx_release: assert property (
    @(posedge mclk) disable iff (rst)
    (byte_done && state_q == st_tx)
      |=> !sda_oe_q && (state_q == st_tx_ack))
    else $error("sda not released after eighth bit");

  a_read_more: assert property (
    @(posedge mclk) disable iff (rst)
    (ev.fall && state_q == st_tx_ack && mack_q)
      |=> sda_oe_q && (tx_q == {1'b0, wiper_q}) && (state_q == st_tx))
    else $error("read stopped despite master ack");

  a_write_standby: assert property (
    @(posedge mclk) disable iff (rst)
    (ev.fall && state_q == st_wdata_ack)
      |=> (state_q == st_idle) && !sda_oe_q)
    else $error("no standby after write");

  a_read_id_ack: assert property (
    @(posedge mclk) disable iff (rst)
    (byte_done && state_q == st_id && id_ok && shift_q[`DIR_BIT])
      |=> sda_oe_q && dir_rd_q)
    else $error("read id not acknowledged");

  a_no_start: assert property (
    @(posedge mclk) disable iff (rst)
    (state_q == st_idle && !start_ok) |=> (state_q == st_idle) && !sda_oe_q)
    else $error("left idle without start");

  a_wiper_hold: assert property (
    @(posedge mclk) disable iff (rst)
    !(byte_done && state_q == st_wdata) |=> $stable(wiper_q))
    else $error("wiper changed outside a data byte");

endmodule

// [wiper_bus_master.sv]
// behavioural two-wire bus master that drives scl and its share of sda
// assumes sda_wire is the wired-and of all sda drivers with a pull-up
module wiper_bus_master (
  input  wire logic mclk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF = 50;
  localparam int QTR  = 20;

  // ----------------------------------------
  // idle: both lines released, scl stands still
  // ----------------------------------------
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // ----------------------------------------
  // conditions and bits
  // ----------------------------------------
  task automatic start_cond();
    @(posedge mclk);
    #1;
    sda_drv = 1'b1;
    // a slave letting go of its ack needs time before scl rises
    #HALF;
    scl = 1'b1;
    #HALF;
    sda_drv = 1'b0;
    #HALF;
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    #QTR;
    sda_drv = 1'b0;
    #(HALF - QTR);
    scl = 1'b1;
    #HALF;
    sda_drv = 1'b1;
    #HALF;
  endtask

  // scl low with sda released: no condition appears on the bus
  task automatic scl_low();
    @(posedge mclk);
    #1;
    scl = 1'b0;
  endtask

  // sda moves only in the low half; level sampled at the end of the high half
  task automatic put_bit(input logic b, output logic seen);
    #QTR;
    sda_drv = b;
    #(HALF - QTR);
    scl = 1'b1;
    #(HALF - 1);
    seen = sda_wire;
    #1;
    scl = 1'b0;
  endtask

  // ack is 1 when the slave pulled sda low in the ninth clock
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], s);
    end
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic rbyte(input logic give_ack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, v[i]);
    end
    put_bit(~give_ack, s);
  endtask
endmodule

// [serial_wiper_position_slave_test.sv]
// self-checking bench for the wiper position slave
// assumes wiper_bus_master.sv as the far side and an external pull-up on sda
`include "wiper_map.svh"

module serial_wiper_position_slave_test;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [6:0] CODE  = 7'h3a; // arbitrary device code
  localparam int         LIMIT = 30000;

  logic               mclk;
  logic               rst;
  logic               clk_en;
  logic               scl;
  logic               sda_drv;
  logic               sda_wire;
  logic               sda_out;
  logic               sda_oe;
  logic               pwrup_busy;
  logic [`WIPER_W-1:0] wiper_pos;
  logic [2:0]         acks;
  logic [7:0]         rd0;
  logic [7:0]         rd1;
  logic [7:0]         vals [3] = '{8'h7f, 8'h00, 8'hd5};
  int                 failures;
  int                 check_count;
  int                 cycles;

  // ----------------------------------------
  // wiring
  // ----------------------------------------
  assign sda_wire = sda_drv & ~(sda_oe & ~sda_out);

  serial_wiper_position_slave #(.DEV_CODE(CODE)) DUT (
    .mclk      (mclk),
    .rst       (rst),
    .clk_en    (clk_en),
    .scl_in    (scl),
    .sda_in    (sda_wire),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe),
    .wiper_pos (wiper_pos),
    .pwrup_busy(pwrup_busy)
  );

  wiper_bus_master m (
    .mclk    (mclk),
    .sda_wire(sda_wire),
    .scl     (scl),
    .sda_drv (sda_drv)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      results();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic write_reg(input logic [7:0] id, input logic [7:0] addr, input logic [7:0] data,
                           output logic [2:0] ak);
    m.start_cond();
    m.wbyte(id, ak[2]);
    m.wbyte(addr, ak[1]);
    m.wbyte(data, ak[0]);
    m.stop_cond();
  endtask

  task automatic read_reg(output logic [2:0] ak, output logic [7:0] b0, output logic [7:0] b1);
    m.start_cond();
    m.wbyte({CODE, 1'b0}, ak[2]);
    m.wbyte(8'h00, ak[1]);
    m.start_cond();
    m.wbyte({CODE, 1'b1}, ak[0]);
    m.rbyte(1'b1, b0);
    m.rbyte(1'b0, b1);
    m.stop_cond();
  endtask

  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    rst         = 1'b1;
    clk_en      = 1'b1;
    failures    = 0;
    check_count = 0;
    cycles      = 0;
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    check("wiper_pos", {1'b0, wiper_pos}, 8'h40);
    check("sda_oe", {7'h00, sda_oe}, 8'h00);
    check("pwrup_busy", {7'h00, pwrup_busy}, 8'h01);
    // transfer begun while power-up runs is ignored to its end
    write_reg({CODE, 1'b0}, 8'h00, 8'h11, acks);
    check("busy acks", {5'h00, acks}, 8'h00);
    check("wiper_pos", {1'b0, wiper_pos}, 8'h40);
    check("pwrup_busy", {7'h00, pwrup_busy}, 8'h00);
    foreach (vals[i]) begin
      write_reg({CODE, 1'b0}, 8'h00, vals[i], acks);
      check("write acks", {5'h00, acks}, 8'h07);
      check("wiper_pos", {1'b0, wiper_pos}, {1'b0, vals[i][6:0]});
      read_reg(acks, rd0, rd1);
      check("read acks", {5'h00, acks}, 8'h07);
      check("read byte 0", rd0, {1'b0, vals[i][6:0]});
      check("read byte 1", rd1, {1'b0, vals[i][6:0]});
    end
    write_reg({CODE, 1'b0}, 8'h01, 8'h33, acks);
    check("bad addr acks", {5'h00, acks}, 8'h04);
    check("wiper_pos", {1'b0, wiper_pos}, 8'h55);
    write_reg({CODE ^ 7'h01, 1'b0}, 8'h00, 8'h33, acks);
    check("bad id acks", {5'h00, acks}, 8'h00);
    check("wiper_pos", {1'b0, wiper_pos}, 8'h55);
    // bytes with no start before them draw no answer
    m.scl_low();
    m.wbyte({CODE, 1'b0}, acks[2]);
    m.wbyte(8'h00, acks[1]);
    m.wbyte(8'h22, acks[0]);
    m.stop_cond();
    check("no start acks", {5'h00, acks}, 8'h00);
    check("wiper_pos", {1'b0, wiper_pos}, 8'h55);
    check("sda_oe", {7'h00, sda_oe}, 8'h00);
    // a frozen block answers nothing
    clk_en = 1'b0;
    write_reg({CODE, 1'b0}, 8'h00, 8'h2a, acks);
    check("frozen acks", {5'h00, acks}, 8'h00);
    check("wiper_pos", {1'b0, wiper_pos}, 8'h55);
    clk_en = 1'b1;
    // reset in mid-run brings the wiper back to midscale
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    check("wiper_pos", {1'b0, wiper_pos}, 8'h40);
    check("pwrup_busy", {7'h00, pwrup_busy}, 8'h01);
    check("sda_out", {7'h00, sda_out}, 8'h00);
    repeat (`PWRUP_CYC + 10) @(posedge mclk);
    read_reg(acks, rd0, rd1);
    check("read acks", {5'h00, acks}, 8'h07);
    check("read after reset", rd0, 8'h40);
    results();
  end
endmodule
